//--- rtl/see_slave.sv
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/1ns
module see_slave #(
   parameter int WRITE_CYC   = see_pkg::WRITE_CYCLE_CYC,
   parameter int POWERUP_CYC = see_pkg::POWERUP_READY_CYC
) (
   // Clock and supply-monitor reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Bus side
   see_bus_if.dev          bus,
   // Strap and protect pins, pulled low inside the package
   input  wire logic       strap_select_bit0_i,
   input  wire logic       strap_select_bit1_i,
   input  wire logic       strap_select_bit2_i,
   input  wire logic       wp_i,
   // Read data supplied by the array
   input  wire logic [7:0] tx_data_i,
   output logic            tx_req_o,
   // Received bytes of a write request
   output logic [7:0]      rx_data_o,
   output logic [1:0]      rx_index_o,
   output logic            rx_valid_o,
   // Status
   output logic            write_start_o,
   output logic            wp_reject_o,
   output logic            busy_o,
   output logic            ready_o
);

   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RXEND, ST_ACK_OUT, ST_TX, ST_ACK_IN} see_st_t;

   // Input synchronisers and filter state
   logic [5:0] pin_s1_reg;
   logic [5:0] pin_s2_reg;
   logic [1:0] flt_reg;
   logic [1:0] flt_d_reg;
   logic [4:0] fcnt_reg [2];

   // Protocol state
   see_st_t    state_reg, state_next;
   logic [2:0] bit_cnt_reg, bit_cnt_next;
   logic [7:0] shift_reg, shift_next;
   logic [1:0] byte_cnt_reg, byte_cnt_next;
   logic       is_addr_reg, is_addr_next;
   logic       rw_reg, rw_next;
   logic       wp_lock_reg, wp_lock_next;
   logic       wr_pend_reg, wr_pend_next;
   logic       sda_oe_reg, sda_oe_next;
   logic [7:0] rx_data_next;
   logic       rx_valid_next;
   logic       tx_req_next;
   logic       wp_rej_next;
   logic       wr_launch;
   localparam int TIMER_W = see_pkg::TIMER_W;
   logic [TIMER_W-1:0] busy_cnt_reg;
   logic [TIMER_W-1:0] pu_cnt_reg;

   // Decoded bus events
   wire       scl_f     = flt_reg[0];
   wire       sda_f     = flt_reg[1];
   wire       scl_rise  = scl_f && !flt_d_reg[0];
   wire       scl_fall  = !scl_f && flt_d_reg[0];
   wire       start_ev  = scl_f && flt_d_reg[0] && flt_d_reg[1] && !sda_f;
   wire       stop_ev   = scl_f && flt_d_reg[0] && !flt_d_reg[1] && sda_f;
   wire [2:0] strap     = pin_s2_reg[4:2];
   wire       wp_s      = pin_s2_reg[5];
   wire       addr_hit  = (shift_reg[7:4] == see_pkg::DEV_TYPE_CODE) && (shift_reg[3:1] == strap);
   wire       data_byte = byte_cnt_reg >= see_pkg::DATA_BYTE_IDX;

   // two flops on every pin before use
   // open straps arrive as low through the package pull-down
   // open protect pin arrives as low
   always_ff @(posedge clk_i) begin
      pin_s1_reg <= {wp_i, strap_select_bit2_i, strap_select_bit1_i, strap_select_bit0_i,
                     bus.sda, bus.scl};
      pin_s2_reg <= pin_s1_reg;
   end

   // a level change must outlast the noise window
   generate
      for (genvar g = 0; g < 2; g++) begin : g_filt
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               fcnt_reg[g] <= 5'h00;
               flt_reg[g]  <= 1'b1;
            end else if (pin_s2_reg[g] == flt_reg[g]) begin
               fcnt_reg[g] <= 5'h00;
            end else if (fcnt_reg[g] == see_pkg::FILT_CNT_MAX) begin
               fcnt_reg[g] <= 5'h00;
               flt_reg[g]  <= pin_s2_reg[g];
            end else begin
               fcnt_reg[g] <= fcnt_reg[g] + 5'h01;
            end
         end
      end
   endgenerate

   // Protocol next state
   always_comb begin
      state_next    = state_reg;
      bit_cnt_next  = bit_cnt_reg;
      shift_next    = shift_reg;
      byte_cnt_next = byte_cnt_reg;
      is_addr_next  = is_addr_reg;
      rw_next       = rw_reg;
      wp_lock_next  = wp_lock_reg;
      wr_pend_next  = wr_pend_reg;
      sda_oe_next   = sda_oe_reg;
      rx_data_next  = rx_data_o;
      rx_valid_next = 1'b0;
      tx_req_next   = 1'b0;
      wp_rej_next   = 1'b0;
      wr_launch     = 1'b0;
      if (stop_ev) begin
         // STOP ends the command and releases SDA
         state_next  = ST_IDLE;
         sda_oe_next = 1'b0;
         // STOP after accepted data starts the write cycle
         wr_launch    = wr_pend_reg;
         wr_pend_next = 1'b0;
      end else if (start_ev && ready_o) begin
         // only a START opens a transfer
         state_next    = ST_RX;
         is_addr_next  = 1'b1;
         bit_cnt_next  = 3'h0;
         byte_cnt_next = 2'h0;
         wp_lock_next  = 1'b0;
         sda_oe_next   = 1'b0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
            end
            ST_RX: begin
               // data taken on the rising edge
               if (scl_rise) begin
                  shift_next   = {shift_reg[6:0], sda_f};
                  bit_cnt_next = bit_cnt_reg + 3'h1;
                  if (bit_cnt_reg == see_pkg::BIT_LAST) begin
                     state_next = ST_RXEND;
                  end
               end
            end
            ST_RXEND: begin
               // acknowledge by pulling low in the ninth clock
               if (scl_fall) begin
                  if (is_addr_reg) begin
                     // no answer to the own address while busy
                     if (addr_hit && !busy_o) begin
                        rw_next     = shift_reg[0];
                        sda_oe_next = 1'b1;
                        state_next  = ST_ACK_OUT;
                     end else begin
                        state_next = ST_IDLE;
                     end
                  end else if (data_byte && wp_lock_reg) begin
                     wp_rej_next  = 1'b1;
                     wr_pend_next = 1'b0;
                     state_next   = ST_IDLE;
                  end else begin
                     rx_data_next  = shift_reg;
                     rx_valid_next = 1'b1;
                     wr_pend_next  = wr_pend_reg || data_byte;
                     sda_oe_next   = 1'b1;
                     state_next    = ST_ACK_OUT;
                  end
               end
            end
            ST_ACK_OUT: begin
               if (scl_fall) begin
                  is_addr_next = 1'b0;
                  bit_cnt_next = 3'h0;
                  if (rw_reg) begin
                     // a one is sent by releasing the line
                     shift_next  = tx_data_i;
                     sda_oe_next = !tx_data_i[7];
                     tx_req_next = 1'b1;
                     state_next  = ST_TX;
                  end else begin
                     sda_oe_next = 1'b0;
                     state_next  = ST_RX;
                     if (!is_addr_reg && !data_byte) begin
                        byte_cnt_next = byte_cnt_reg + 2'h1;
                     end
                     // strobe protect on the fall before data
                     if (!is_addr_reg && byte_cnt_reg == see_pkg::WADDR_LAST) begin
                        wp_lock_next = wp_s;
                     end
                  end
               end
            end
            ST_TX: begin
               // outgoing bits change after the falling edge
               if (scl_fall) begin
                  if (bit_cnt_reg == see_pkg::BIT_LAST) begin
                     // transmitter releases for the ninth clock
                     sda_oe_next = 1'b0;
                     state_next  = ST_ACK_IN;
                  end else begin
                     shift_next   = {shift_reg[6:0], 1'b0};
                     sda_oe_next  = !shift_reg[6];
                     bit_cnt_next = bit_cnt_reg + 3'h1;
                  end
               end
            end
            ST_ACK_IN: begin
               // Master acknowledge keeps the read going, none ends it
               if (scl_rise) begin
                  state_next = sda_f ? ST_IDLE : ST_ACK_OUT;
               end
            end
         endcase
      end
   end

   // reset puts every control flop in its idle value
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg    <= ST_IDLE;
         bit_cnt_reg  <= 3'h0;
         shift_reg    <= 8'h00;
         byte_cnt_reg <= 2'h0;
         is_addr_reg  <= 1'b0;
         rw_reg       <= 1'b0;
         wp_lock_reg  <= 1'b0;
         wr_pend_reg  <= 1'b0;
         sda_oe_reg   <= 1'b0;
         flt_d_reg    <= 2'h3;
      end else begin
         state_reg    <= state_next;
         bit_cnt_reg  <= bit_cnt_next;
         shift_reg    <= shift_next;
         byte_cnt_reg <= byte_cnt_next;
         is_addr_reg  <= is_addr_next;
         rw_reg       <= rw_next;
         wp_lock_reg  <= wp_lock_next;
         wr_pend_reg  <= wr_pend_next;
         sda_oe_reg   <= sda_oe_next;
         flt_d_reg    <= flt_reg;
      end
   end

   // User-side strobes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_data_o     <= 8'h00;
         rx_index_o    <= 2'h0;
         rx_valid_o    <= 1'b0;
         tx_req_o      <= 1'b0;
         wp_reject_o   <= 1'b0;
         write_start_o <= 1'b0;
      end else begin
         rx_data_o     <= rx_data_next;
         rx_index_o    <= byte_cnt_reg;
         rx_valid_o    <= rx_valid_next;
         tx_req_o      <= tx_req_next;
         wp_reject_o   <= wp_rej_next;
         write_start_o <= wr_launch;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_cnt_reg <= '0;
         busy_o       <= 1'b0;
         pu_cnt_reg   <= '0;
         ready_o      <= 1'b0;
      end else begin
         if (wr_launch) begin
            busy_cnt_reg <= TIMER_W'(WRITE_CYC - 1);
            busy_o       <= 1'b1;
         end else if (busy_cnt_reg != '0) begin
            busy_cnt_reg <= busy_cnt_reg - 1'b1;
         end else begin
            busy_o <= 1'b0;
         end
         if (pu_cnt_reg == TIMER_W'(POWERUP_CYC - 1)) begin
            ready_o <= 1'b1;
         end else begin
            pu_cnt_reg <= pu_cnt_reg + 1'b1;
         end
      end
   end

   // no clock output exists on this end
   assign bus.dev_sda_o  = 1'b0;
   assign bus.dev_sda_oe = sda_oe_reg;

endmodule // see_slave

//--- rtl/see_pkg.sv
package see_pkg;

   // Sampling clock
   localparam int CLK_NS = 4;

   // Input noise filter: a pulse up to this width is dropped
   localparam int NOISE_FILTER_WIDTH_NS = 100;
   localparam int NOISE_FILTER_CYC = (NOISE_FILTER_WIDTH_NS + CLK_NS - 1) / CLK_NS;
   // Level must hold one sample longer than the widest rejected pulse
   localparam logic [4:0] FILT_CNT_MAX = 5'(NOISE_FILTER_CYC);

   // Internal write cycle, longest time rounded down
   localparam int WRITE_CYCLE_TIME_US = 5000;
   localparam int WRITE_CYCLE_CYC = (WRITE_CYCLE_TIME_US * 1000) / CLK_NS;

   // Reset release to ready, longest time rounded down
   localparam int POWERUP_READY_DELAY_US = 1000;
   localparam int POWERUP_READY_CYC = (POWERUP_READY_DELAY_US * 1000) / CLK_NS;

   // Busy and power-up counter width
   localparam int TIMER_W = 21;

   // Device-type code in the upper address nibble; value is arbitrary
   localparam logic [3:0] DEV_TYPE_CODE = 4'h5;

   // Bit and byte positions within a transfer
   localparam logic [2:0] BIT_LAST      = 3'h7;
   localparam logic [1:0] WADDR_LAST    = 2'h1;
   localparam logic [1:0] DATA_BYTE_IDX = 2'h2;
   localparam logic [3:0] HBIT_LAST     = 4'h8;

   // Controller quarter bit period, least time rounded up
   localparam int HOST_QTR_NS = 625;
   localparam int HOST_QTR_CYC = (HOST_QTR_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0] HOST_QTR_MAX = 8'(HOST_QTR_CYC - 1);

   // Controller register map (byte addresses)
   localparam logic [3:0] REG_CMD_OFS  = 4'h0;
   localparam logic [3:0] REG_STAT_OFS = 4'h4;

   // Command register fields
   localparam int CMD_OP_LSB   = 0;
   localparam int CMD_ACK_BIT  = 2;
   localparam int CMD_DATA_LSB = 8;

   // Status register fields
   localparam int STAT_BUSY_BIT  = 0;
   localparam int STAT_NACK_BIT  = 1;
   localparam int STAT_REFU_BIT  = 2;
   localparam int STAT_FRAME_BIT = 3;
   localparam int STAT_DATA_LSB  = 8;

   // Controller commands
   typedef enum logic [1:0] {
      OP_START,
      OP_WRITE,
      OP_READ,
      OP_STOP
   } see_op_t;

endpackage

//--- rtl/see_bus_if.sv
`timescale 1ns/1ns
// Two-wire bus: each party only pulls low, the pull-up wins otherwise
interface see_bus_if;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic scl;
   logic sda;

   // Wired-AND of all drivers
   assign scl = !(host_scl_oe && !host_scl_o);
   assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

   modport dev (
      input  scl,
      input  sda,
      output dev_sda_o,
      output dev_sda_oe
   );

   modport host (
      input  scl,
      input  sda,
      output host_scl_o,
      output host_scl_oe,
      output host_sda_o,
      output host_sda_oe
   );
endinterface // see_bus_if

//--- rtl/see_master.sv
`timescale 1ns/1ns
// Bus controller: one command per register write, status read back
module see_master (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Classic Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // Bus side
   see_bus_if.host          bus
);

   typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} see_hst_t;

   see_hst_t   state_reg;
   logic [1:0] scl_s1_reg, scl_s2_reg;
   logic [1:0] sda_s1_reg, sda_s2_reg;
   logic [7:0] qcnt_reg;
   logic [1:0] phase_reg;
   logic [3:0] bit_reg;
   logic [8:0] out_reg;
   logic [8:0] in_reg;
   logic [7:0] rdata_reg;
   logic       nack_reg;
   logic       refused_reg;
   logic       frame_reg;
   logic       scl_oe_reg;
   logic       sda_oe_reg;

   // Register decode
   wire            req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire            cmd_sel  = wb_adr_i == see_pkg::REG_CMD_OFS;
   wire            stat_sel = wb_adr_i == see_pkg::REG_STAT_OFS;
   wire            cmd_wr   = req && wb_we_i && cmd_sel && wb_sel_i[0];
   wire see_pkg::see_op_t op = see_pkg::see_op_t'(wb_dat_i[see_pkg::CMD_OP_LSB +: 2]);
   wire [7:0]      wdata    = wb_dat_i[see_pkg::CMD_DATA_LSB +: 8];
   wire            ack_bit  = wb_dat_i[see_pkg::CMD_ACK_BIT];
   wire            bus_free = scl_s2_reg[1] && sda_s2_reg[1];
   // start on idle bus or within an open frame
   // START needs an idle bus or an open frame; STOP and bytes need a frame
   wire            op_ok    = (op == see_pkg::OP_START) ? (frame_reg || bus_free) : frame_reg;
   wire            accept   = cmd_wr && state_reg == H_IDLE && op_ok;
   wire            tick     = qcnt_reg == see_pkg::HOST_QTR_MAX;
   wire            busy     = state_reg != H_IDLE;
   wire [31:0]     stat_w   = {16'h0000, rdata_reg, 4'h0, frame_reg, refused_reg, nack_reg, busy};
   wire [31:0]     rd_w     = (stat_sel && !wb_we_i) ? stat_w : 32'h0000_0000;

   // Line synchronisers, second stage only is read
   always_ff @(posedge clk_i) begin
      scl_s1_reg <= {scl_s1_reg[0], bus.scl};
      sda_s1_reg <= {sda_s1_reg[0], bus.sda};
      scl_s2_reg <= scl_s1_reg;
      sda_s2_reg <= sda_s1_reg;
   end

   // Wishbone answer one cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= rd_w;
      end
   end

   // Quarter-period divider, restarted on every accepted command
   always_ff @(posedge clk_i) begin
      if (rst_i || accept || tick || !busy) begin
         qcnt_reg <= 8'h00;
      end else begin
         qcnt_reg <= qcnt_reg + 8'h01;
      end
   end

   // data held while clock high
   // Command sequencer; data bits move SDA only while SCL is held low
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg   <= H_IDLE;
         phase_reg   <= 2'h0;
         bit_reg     <= 4'h0;
         out_reg     <= 9'h1FF;
         in_reg      <= 9'h000;
         rdata_reg   <= 8'h00;
         nack_reg    <= 1'b0;
         refused_reg <= 1'b0;
         frame_reg   <= 1'b0;
         scl_oe_reg  <= 1'b0;
         sda_oe_reg  <= 1'b0;
      end else if (cmd_wr && !accept) begin
         refused_reg <= 1'b1;
      end else if (accept) begin
         refused_reg <= 1'b0;
         phase_reg   <= 2'h0;
         bit_reg     <= 4'h0;
         unique case (op)
            see_pkg::OP_START: state_reg <= H_START;
            see_pkg::OP_STOP:  state_reg <= H_STOP;
            default:           state_reg <= H_BIT;
         endcase
         out_reg <= (op == see_pkg::OP_WRITE) ? {wdata, 1'b1} : {8'hFF, !ack_bit};
      end else if (tick) begin
         phase_reg <= phase_reg + 2'h1;
         unique case (state_reg)
            H_START: begin
               sda_oe_reg <= (phase_reg >= 2'h2);
               scl_oe_reg <= (phase_reg == 2'h3);
               frame_reg  <= 1'b1;
            end
            H_STOP: begin
               // Data released from the fourth quarter on, or a false START follows
               sda_oe_reg <= (phase_reg < 2'h2);
               scl_oe_reg <= (phase_reg == 2'h0);
               frame_reg  <= (phase_reg != 2'h3);
            end
            H_BIT: begin
               if (phase_reg == 2'h0) begin
                  sda_oe_reg <= !out_reg[8];
               end
               scl_oe_reg <= (phase_reg == 2'h3) || (phase_reg == 2'h0);
               if (phase_reg == 2'h2) begin
                  in_reg <= {in_reg[7:0], sda_s2_reg[1]};
               end
               if (phase_reg == 2'h3) begin
                  out_reg <= {out_reg[7:0], 1'b1};
                  bit_reg <= bit_reg + 4'h1;
               end
            end
            default: begin
            end
         endcase
         if (phase_reg == 2'h3 && (state_reg != H_BIT || bit_reg == see_pkg::HBIT_LAST)) begin
            state_reg <= H_IDLE;
            if (state_reg == H_BIT) begin
               // Eight data bits sit above the ninth sampled bit
               rdata_reg <= in_reg[8:1];
               nack_reg  <= in_reg[0];
            end
         end
      end
   end

   // lines only pulled low or released
   // Open-drain drivers
   assign bus.host_scl_o  = 1'b0;
   assign bus.host_scl_oe = scl_oe_reg;
   assign bus.host_sda_o  = 1'b0;
   assign bus.host_sda_oe = sda_oe_reg;

endmodule // see_master

//--- testbench/see_bus_assertions.sv
`timescale 1ns/1ns
// Watches the shared lines beside the bus joining both ends
module see_bus_assertions (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus lines
   input wire logic scl,
   input wire logic sda,
   input wire logic dev_sda_o,
   input wire logic dev_sda_oe
);
   logic       seen_reg;
   logic [7:0] low_reg;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Bus conditions on the raw lines
   sequence start_cond; scl && $fell(sda); endsequence
   sequence stop_cond; scl && $rose(sda); endsequence
   // Frame seen since reset; cycles since SCL fell, saturating so it never wraps
   always_ff @(posedge clk_i) begin
      seen_reg <= !rst_i && (seen_reg || (scl && $fell(sda)));
      low_reg  <= rst_i ? 8'hFF : ($fell(scl) ? 8'h00 : low_reg + 8'(low_reg != 8'hFF));
   end
   a_open_drain: assert property (dev_sda_oe |-> !dev_sda_o && !sda)
      else $error("device data line not pulled low");
   a_quiet_idle: assert property (!seen_reg |-> !dev_sda_oe)
      else $error("device drove before any start");
   a_stable_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
      else $error("device data moved while clock high");
   a_after_fall: assert property ($changed(dev_sda_oe) |->
      !scl && low_reg >= 8'h10 && low_reg <= 8'h30)
      else $error("device data moved outside its slot");
   a_filter_hold: assert property ($fell(scl) |=> $stable(dev_sda_oe) [*8])
      else $error("device reacted faster than its filter");
   a_free_stop: assert property (stop_cond |-> ##1 (!dev_sda_oe) [*8])
      else $error("device drove after stop");
   a_free_start: assert property (start_cond |-> ##1 (!dev_sda_oe) [*8])
      else $error("device drove after start");
   a_data_setup: assert property ($rose(scl) |-> sda == $past(sda, 25))
      else $error("data moved too near clock rise");
   a_scl_low: assert property ($fell(scl) |=> (!scl) [*8])
      else $error("clock low period too short");
endmodule // see_bus_assertions

//--- testbench/test_serial_eeprom_bus_slave_front_end.sv
`timescale 1ns/1ns
// Controller and device on one bus; commands go in over Wishbone
module test_serial_eeprom_bus_slave_front_end;
   localparam int PU = 100;
   localparam int WR = 8000;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0;
   logic        we = 1'b0;
   logic [3:0]  adr = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat, st;
   logic [2:0]  strap = 3'h5;
   logic        wp = 1'b0;
   logic [7:0]  txd = 8'h3C;
   logic [7:0]  rxd, rx_last;
   logic [1:0]  rxi, rx_idx;
   logic        ack, rxv, wst, wrj, busy, rdy, trq;
   int          n_tr = 0;
   int          n_mismatch = 0;
   int          checked = 0;
   int          n_ws = 0;
   int          n_wr = 0;
   wire  [7:0]  a_w = {see_pkg::DEV_TYPE_CODE, strap, 1'b0};

   see_bus_if bus ();
   see_slave #(.WRITE_CYC(WR), .POWERUP_CYC(PU)) i_see_slave (
      .clk_i(clk_i), .rst_i(rst_i), .bus(bus), .strap_select_bit0_i(strap[0]),
      .strap_select_bit1_i(strap[1]), .strap_select_bit2_i(strap[2]), .wp_i(wp),
      .tx_data_i(txd), .tx_req_o(trq), .rx_data_o(rxd), .rx_index_o(rxi), .rx_valid_o(rxv),
      .write_start_o(wst), .wp_reject_o(wrj), .busy_o(busy), .ready_o(rdy));
   see_master i_see_master (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(rdat),
      .wb_ack_o(ack), .bus(bus));
   see_bus_assertions i_see_bus_assertions (
      .clk_i(clk_i), .rst_i(rst_i), .scl(bus.scl), .sda(bus.sda),
      .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe));

   always #2 clk_i = ~clk_i;

   // Device pulses last one cycle, so latch or count them here
   always @(posedge clk_i) begin
      if (rxv === 1'b1) begin
         rx_last <= rxd;
         rx_idx  <= rxi;
      end
      if (wst === 1'b1) n_ws++;
      if (wrj === 1'b1) n_wr++;
      if (trq === 1'b1) n_tr++;
   end

   task close_out;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One classic cycle; no answer time is assumed, the watchdog ends a hang
   task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      cyc  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      st = rdat;
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask

   // Command, then poll status until the controller is idle
   task cmd(input logic [1:0] op, input logic [7:0] d);
      wb(1'b1, see_pkg::REG_CMD_OFS, {16'h0, d, 6'h0, op});
      do wb(1'b0, see_pkg::REG_STAT_OFS, 32'h0); while (st[0] !== 1'b0);
   endtask

   // Start plus address byte; nk is the expected ninth bit
   task head(input logic [7:0] a, input logic nk);
      cmd(see_pkg::OP_START, 8'h0);
      cmd(see_pkg::OP_WRITE, a);
      chk(8'(st[1]), 8'(nk));
   endtask

   task t_power;
      int n;
      n = 0;
      while (rdy !== 1'b1 && n < 500) begin
         @(posedge clk_i);
         n++;
      end
      chk(8'(n >= PU - 1 && n <= PU + 2), 8'h1);
      $display("power-up test done");
   endtask

   task t_write;
      int n;
      n = 0;
      head(a_w, 1'b0);
      cmd(see_pkg::OP_WRITE, 8'h01);
      cmd(see_pkg::OP_WRITE, 8'h20);
      cmd(see_pkg::OP_WRITE, 8'hA5);
      chk(rx_last, 8'hA5);
      chk(8'({rx_idx, st[1]}), 8'h4);
      cmd(see_pkg::OP_STOP, 8'h0);
      chk(8'({n_ws[1:0], busy}), 8'h3);
      head(a_w, 1'b1);
      cmd(see_pkg::OP_STOP, 8'h0);
      while (busy !== 1'b0 && n < WR) begin
         @(posedge clk_i);
         n++;
      end
      chk(8'(busy), 8'h0);
      $display("write test done");
   endtask

   task t_wp;
      wp <= 1'b1;
      head(a_w, 1'b0);
      cmd(see_pkg::OP_WRITE, 8'h02);
      cmd(see_pkg::OP_WRITE, 8'h00);
      cmd(see_pkg::OP_WRITE, 8'h5A);
      chk(8'({st[1], n_wr[1:0]}), 8'h5);
      cmd(see_pkg::OP_STOP, 8'h0);
      chk(8'({n_ws[1:0], busy}), 8'h2);
      wp <= 1'b0;
      $display("protect test done");
   endtask

   task t_miss;
      wb(1'b0, 4'h8, 32'h0);
      chk(st[7:0], 8'h0);
      head({see_pkg::DEV_TYPE_CODE, strap ^ 3'h4, 1'b0}, 1'b1);
      cmd(see_pkg::OP_STOP, 8'h0);
      head({see_pkg::DEV_TYPE_CODE ^ 4'h1, strap, 1'b1}, 1'b1);
      cmd(see_pkg::OP_STOP, 8'h0);
      $display("address miss test done");
   endtask

   task t_read;
      head({see_pkg::DEV_TYPE_CODE, strap, 1'b1}, 1'b0);
      cmd(see_pkg::OP_READ, 8'h0);
      chk(st[15:8], txd);
      chk(8'(n_tr), 8'h1);
      cmd(see_pkg::OP_STOP, 8'h0);
      $display("read test done");
   endtask

   // Main sequence, ending with a mid-run reset and a second power-up test
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_power;
      t_write;
      t_wp;
      t_miss;
      t_read;
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk(8'({rdy, busy}), 8'h0);
      rst_i <= 1'b0;
      t_power;
      close_out;
   end

   // Watchdog, well past the expected run length
   initial begin
      repeat (100000) @(posedge clk_i);
      n_mismatch++;
      close_out;
   end
endmodule // test_serial_eeprom_bus_slave_front_end
